//--- include/ota_alarm_consts.svh
// constants for the over-temperature alarm block: pointer codes, field positions,
// reset values and the bus address
// assumes inclusion by bare name from the design and bench files
`ifndef OTA_ALARM_CONSTS_SVH
`define OTA_ALARM_CONSTS_SVH

// register pointer codes
`define OTA_PTR_TEMP 2'h0
`define OTA_PTR_CFG 2'h1
`define OTA_PTR_REL 2'h2
`define OTA_PTR_TRIP 2'h3

// settings register field positions
`define OTA_CFG_SHUT_BIT 0
`define OTA_CFG_MODE_BIT 1
`define OTA_CFG_POL_BIT 2
`define OTA_CFG_FQ_LO 3
`define OTA_CFG_FQ_HI 4

// reset values: settings, trip 80 C, release 75 C (0.5 C steps)
`define OTA_CFG_RST 5'h00
`define OTA_TRIP_RST 9'h0a0
`define OTA_REL_RST 9'h096
`define OTA_PTR_RST 2'h0

// fixed upper four bits of the 7-bit bus address, low three from pins
`define OTA_ADDR_HI 4'h9

// bits in a bus byte, acknowledge slot not counted
`define OTA_BYTE_BITS 4'h8

`endif

//--- include/ota_alarm_pkg.sv
// types for the over-temperature alarm block
// assumes the constants header is compiled alongside
package ota_alarm_pkg;

  // settings register fields, bit 0 at the bottom
  typedef struct packed {
    logic [1:0] fault_count_select;
    logic alarm_polarity;
    logic alarm_behaviour_select;
    logic shutdown;
  } ota_cfg_t;

  // one conversion result from the converter
  typedef struct packed {
    logic valid;
    logic [10:0] temp;
  } ota_conv_t;

  // serial slave states
  typedef enum logic [2:0] {
    OTA_ST_IDLE = 3'b000,
    OTA_ST_RECV = 3'b001,
    OTA_ST_ACK = 3'b010,
    OTA_ST_SEND = 3'b011,
    OTA_ST_MACK = 3'b100,
    OTA_ST_NEXT = 3'b101
  } ota_state_t;

endpackage

//--- verilog/ota_alarm.sv
// over-temperature alarm logic with settings, limits and serial register access
// assumes scl, sda and address pins arrive asynchronously, conversions come on the system clock
`timescale 1ns/100ps
`include "ota_alarm_consts.svh"

module ota_alarm (
  input wire logic i_sys_clk, // 250 MHz system clock
  input wire logic i_sys_rst, // synchronous reset, active high
  input wire logic i_clk_en, // freezes all state while low
  input wire logic i_scl, // bus clock pin level
  input wire logic i_sda, // bus data pin level
  input wire logic [2:0] i_addr, // address select pins
  input wire ota_alarm_pkg::ota_conv_t i_conv, // conversion result and strobe
  output logic o_sda_out, // data pin drive value, always low
  output logic o_sda_oe, // data pin enable, low pulls the line low
  output logic o_alarm_out, // alarm pin drive value, always low
  output logic o_alarm_oe, // alarm pin enable, low pulls the pin low
  output logic o_conv_run // high while conversions may run
);

  // ************************************************************
  // decode helpers
  // ************************************************************

  // fault run length from the two-bit field
  function automatic logic [2:0] fault_need(input logic [1:0] code);
    case (code)
      2'b00: fault_need = 3'd1;
      2'b01: fault_need = 3'd2;
      2'b10: fault_need = 3'd4;
      default: fault_need = 3'd6;
    endcase
  endfunction

  logic [10:0] temp_q;
  logic [8:0] trip;
  logic [8:0] release_lim;
  ota_alarm_pkg::ota_cfg_t cfg;

  // byte presented for a read: msb when sel is low
  function automatic logic [7:0] rd_byte(input logic [1:0] ptr, input logic sel);
    case (ptr)
      `OTA_PTR_TEMP: rd_byte = sel ? {temp_q[2:0], 5'h00} : temp_q[10:3];
      `OTA_PTR_CFG: rd_byte = {3'h0, cfg};
      `OTA_PTR_REL: rd_byte = sel ? {release_lim[0], 7'h00} : release_lim[8:1];
      default: rd_byte = sel ? {trip[0], 7'h00} : trip[8:1];
    endcase
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************

  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic [2:0] addr_m, addr_s;

  // two flops per pin, a third copy of scl and sda for edge finding
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      addr_m <= 3'h0;
      addr_s <= 3'h0;
    end
    else if (i_clk_en)
    begin
      scl_m <= i_scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= i_sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
      addr_m <= i_addr;
      addr_s <= addr_m;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  // bus events, gated by the clock enable
  assign scl_rise = i_clk_en & scl_s & ~scl_d;
  assign scl_fall = i_clk_en & ~scl_s & scl_d;
  assign bus_start = i_clk_en & scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop = i_clk_en & scl_s & scl_d & ~sda_d & sda_s;

  // ************************************************************
  // serial slave
  // ************************************************************

  ota_alarm_pkg::ota_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [1:0] byte_idx;
  logic is_read;
  logic [1:0] pointer;
  logic [7:0] msb_hold;
  logic byte_done, rd_clear;
  logic [7:0] rd_hi, rd_lo;

  // both bytes of the selected register, ready for the send slots
  assign rd_hi = rd_byte(pointer, 1'b0);
  assign rd_lo = rd_byte(pointer, 1'b1);

  // a received byte completes on the falling clock after its eighth bit
  assign byte_done = (state == ota_alarm_pkg::OTA_ST_RECV) & scl_fall & (bit_cnt == `OTA_BYTE_BITS);
  // any read address acknowledged counts as a register read
  assign rd_clear = (state == ota_alarm_pkg::OTA_ST_ACK) & scl_fall & is_read & (byte_idx == 2'd1);

  // byte-level protocol: address, pointer, data, acknowledge slots
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      state <= ota_alarm_pkg::OTA_ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      byte_idx <= 2'd0;
      is_read <= 1'b0;
      o_sda_oe <= 1'b1;
    end
    else if (bus_start)
    begin
      state <= ota_alarm_pkg::OTA_ST_RECV; // repeated start also lands here
      bit_cnt <= 4'h0;
      byte_idx <= 2'd0;
      o_sda_oe <= 1'b1;
    end
    else if (bus_stop)
    begin
      state <= ota_alarm_pkg::OTA_ST_IDLE;
      o_sda_oe <= 1'b1;
    end
    else if (i_clk_en)
    begin
      case (state)
        ota_alarm_pkg::OTA_ST_RECV:
        begin
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda_s}; // sampled while clock high
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (byte_done)
          begin
            if (byte_idx != 2'd0 || shreg[7:1] == {`OTA_ADDR_HI, addr_s})
            begin
              o_sda_oe <= 1'b0; // acknowledge low
              state <= ota_alarm_pkg::OTA_ST_ACK;
              if (byte_idx == 2'd0)
                is_read <= shreg[0];
              if (byte_idx != 2'd3)
                byte_idx <= byte_idx + 2'd1;
            end
            else
              state <= ota_alarm_pkg::OTA_ST_IDLE;
          end
        end
        ota_alarm_pkg::OTA_ST_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt <= 4'h0;
            if (is_read)
            begin
              o_sda_oe <= rd_hi[7]; // first bit while clock low
              shreg <= {rd_hi[6:0], 1'b0};
              bit_cnt <= 4'h1;
              state <= ota_alarm_pkg::OTA_ST_SEND;
            end
            else
            begin
              o_sda_oe <= 1'b1;
              state <= ota_alarm_pkg::OTA_ST_RECV;
            end
          end
        end
        ota_alarm_pkg::OTA_ST_SEND:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == `OTA_BYTE_BITS)
            begin
              o_sda_oe <= 1'b1; // release for the host acknowledge
              state <= ota_alarm_pkg::OTA_ST_MACK;
            end
            else
            begin
              o_sda_oe <= shreg[7];
              shreg <= {shreg[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        ota_alarm_pkg::OTA_ST_MACK:
        begin
          if (scl_rise)
            state <= sda_s ? ota_alarm_pkg::OTA_ST_IDLE : ota_alarm_pkg::OTA_ST_NEXT;
        end
        ota_alarm_pkg::OTA_ST_NEXT:
        begin
          if (scl_fall)
          begin
            o_sda_oe <= rd_lo[7]; // second byte
            shreg <= {rd_lo[6:0], 1'b0};
            bit_cnt <= 4'h1;
            state <= ota_alarm_pkg::OTA_ST_SEND;
          end
        end
        default: state <= ota_alarm_pkg::OTA_ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************

  logic shut_entry;
  assign shut_entry = byte_done & (byte_idx == 2'd2) & (pointer == `OTA_PTR_CFG) & shreg[`OTA_CFG_SHUT_BIT]
    & ~cfg.shutdown;

  // pointer, settings and limits written by the host, defaults on reset
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      pointer <= `OTA_PTR_RST;
      cfg <= `OTA_CFG_RST;
      trip <= `OTA_TRIP_RST;
      release_lim <= `OTA_REL_RST;
      msb_hold <= 8'h00;
    end
    else if (byte_done)
    begin
      if (byte_idx == 2'd1)
        pointer <= shreg[1:0];
      else if (byte_idx == 2'd2 && pointer == `OTA_PTR_CFG)
        cfg <= shreg[`OTA_CFG_FQ_HI:`OTA_CFG_SHUT_BIT];
      else if (byte_idx == 2'd2)
        msb_hold <= shreg;
      else if (byte_idx == 2'd3 && pointer == `OTA_PTR_REL)
        release_lim <= {msb_hold, shreg[7]};
      else if (byte_idx == 2'd3 && pointer == `OTA_PTR_TRIP)
        trip <= {msb_hold, shreg[7]};
    end
  end

  // ************************************************************
  // alarm evaluation
  // ************************************************************

  logic conv_take, over, under, seek_low, fault, fire, alarm;
  logic [2:0] fault_cnt;

  assign conv_take = i_clk_en & i_conv.valid & ~cfg.shutdown; // no conversions in shutdown
  assign over = $signed(i_conv.temp[10:2]) > $signed(trip);
  assign under = $signed(i_conv.temp[10:2]) < $signed(release_lim);
  assign fault = seek_low ? under : over;
  assign fire = conv_take & fault & (fault_cnt + 3'd1 >= fault_need(cfg.fault_count_select));

  // capture the latest measurement
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      temp_q <= 11'h000;
    else if (conv_take)
      temp_q <= i_conv.temp;
  end

  // consecutive fault counter and the limit being watched
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      fault_cnt <= 3'd0;
      seek_low <= 1'b0;
    end
    else if (conv_take)
    begin
      if (!fault || fire)
        fault_cnt <= 3'd0;
      else
        fault_cnt <= fault_cnt + 3'd1;
      if (fire)
        seek_low <= ~seek_low;
    end
  end

  // alarm state; a new activation wins over a read or shutdown clear
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      alarm <= 1'b0;
    else if (fire)
      alarm <= cfg.alarm_behaviour_select ? 1'b1 : ~seek_low;
    else if (cfg.alarm_behaviour_select && (rd_clear || shut_entry))
      alarm <= 1'b0;
  end

  // pin drive: open drain, released means high
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      o_alarm_oe <= 1'b1;
      o_alarm_out <= 1'b0;
      o_sda_out <= 1'b0;
      o_conv_run <= 1'b1;
    end
    else if (i_clk_en)
    begin
      o_alarm_oe <= ~(alarm ^ cfg.alarm_polarity);
      o_conv_run <= ~cfg.shutdown;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************

  a_alarm_pin_level: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_clk_en |=> o_alarm_oe == ~($past(alarm) ^ $past(cfg.alarm_polarity)))
    else $error("alarm pin level does not follow polarity");

  a_comp_read_keeps: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (!cfg.alarm_behaviour_select && !conv_take && (rd_clear || shut_entry)) |=> $stable(alarm))
    else $error("comparator alarm changed without a conversion");

  a_read_clears_int: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (cfg.alarm_behaviour_select && rd_clear && !fire) |=> !alarm)
    else $error("register read did not clear interrupt alarm");

  a_shut_entry_clear: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (cfg.alarm_behaviour_select && shut_entry && !fire) |=> !alarm && cfg.shutdown)
    else $error("shutdown entry did not clear interrupt alarm");

  a_fault_run_reset: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (conv_take && !fault) |=> fault_cnt == 3'd0)
    else $error("fault run not restarted");

  a_fault_run_need: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $rose(seek_low) |-> $past(fault_cnt) + 3'd1 >= fault_need($past(cfg.fault_count_select)))
    else $error("alarm fired before the fault run was complete");

  a_shut_no_conv: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (cfg.shutdown && i_clk_en) |=> $stable(temp_q) && $stable(fault_cnt) && !o_conv_run)
    else $error("conversion accepted in shutdown");

  a_sda_stable_high: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (scl_s && scl_d && !bus_start && !bus_stop && state != ota_alarm_pkg::OTA_ST_IDLE) |=> $stable(o_sda_oe))
    else $error("data line changed while clock high");

  a_ack_drives_low: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (byte_done && byte_idx != 2'd0 && !bus_start && !bus_stop) |=> !o_sda_oe && state == ota_alarm_pkg::OTA_ST_ACK)
    else $error("data byte not acknowledged");

  a_bit_count_max: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    bit_cnt <= `OTA_BYTE_BITS)
    else $error("more than eight bits counted in a byte");

endmodule // ota_alarm

//--- dv/ota_host.sv
// bus host model: start, stop, byte transfers and register access
// assumes the bench ands o_sda with the device drive and pulls the line up
`timescale 1ns/100ps

module ota_host (
  input wire logic i_sys_clk, // timing reference
  input wire logic i_sda, // resolved data wire
  output logic o_scl, // bus clock, high when idle
  output logic o_sda // data drive, 1 releases
);
  // ****************
  // bus primitives
  // ****************
  // idle bus, both lines released
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // one clock pulse, data moves only while the clock is low
  task automatic bit_x(input logic b, output logic r);
    @(posedge i_sys_clk) o_sda <= b;
    repeat (3) @(posedge i_sys_clk);
    o_scl <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    r = i_sda;
    o_scl <= 1'b0;
  endtask

  // data edge while the clock is high: (1,0) start, (0,1) stop
  task automatic cond(input logic a, input logic b);
    @(posedge i_sys_clk) o_sda <= a;
    repeat (3) @(posedge i_sys_clk);
    o_scl <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    o_sda <= b;
    repeat (4) @(posedge i_sys_clk);
    o_scl <= b;
  endtask

  // eight bits then a released slot for the device ack
  task automatic tx(input logic [7:0] d, output logic nak);
    for (int i = 7; i >= 0; i--) bit_x(d[i], nak);
    bit_x(1'b1, nak);
  endtask

  // line released while the device sends, then own ack or not-ack
  task automatic rx(input logic ak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(ak, r);
  endtask

  // pointer write plus n data bytes; nak high if any ack was missing
  task automatic wr(input logic [6:0] a, input logic [1:0] p, input int n, input logic [15:0] d, output logic nak);
    logic k;
    cond(1'b1, 1'b0);
    tx({a, 1'b0}, nak);
    tx({6'h00, p}, k);
    nak = nak | k;
    for (int i = 0; i < n; i++)
    begin
      tx(d[15 - 8 * i -: 8], k);
      nak = nak | k;
    end
    cond(1'b0, 1'b1);
  endtask

  // pointer write, repeated start, two byte read
  task automatic rd(input logic [6:0] a, input logic [1:0] p, output logic [15:0] d, output logic nak);
    logic k;
    cond(1'b1, 1'b0);
    tx({a, 1'b0}, nak);
    tx({6'h00, p}, k);
    nak = nak | k;
    cond(1'b1, 1'b0);
    tx({a, 1'b1}, k);
    nak = nak | k;
    rx(1'b0, d[15:8]);
    rx(1'b1, d[7:0]);
    cond(1'b0, 1'b1);
  endtask
endmodule // ota_host

//--- dv/ota_alarm_tb.sv
// self-checking bench for the over-temperature alarm block
// assumes the package, the design and the host model are compiled first
`timescale 1ns/100ps
`include "ota_alarm_consts.svh"

module ota_alarm_tb;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [2:0] pins = 3'h5;
  ota_alarm_pkg::ota_conv_t conv = '0;
  logic scl, host_sda, sda_w, sda_out, sda_oe, alarm_out, alarm_oe, conv_run, nak_x;
  int miscompares = 0;
  int checks_done = 0;
  int trip, rel, cnt, r;
  int nq[4] = '{1, 2, 4, 6};
  logic [4:0] cfg;
  logic alarm, dir_up;
  logic [10:0] last_t;
  logic [6:0] dev;

  // clock and open-drain data wire
  always #2 i_sys_clk = ~i_sys_clk;
  assign sda_w = host_sda & (sda_oe | sda_out);

  ota_alarm u_dut (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(clk_en),
    .i_scl(scl),
    .i_sda(sda_w),
    .i_addr(pins),
    .i_conv(conv),
    .o_sda_out(sda_out),
    .o_sda_oe(sda_oe),
    .o_alarm_out(alarm_out),
    .o_alarm_oe(alarm_oe),
    .o_conv_run(conv_run)
  );

  ota_host u_host (
    .i_sys_clk(i_sys_clk),
    .i_sda(sda_w),
    .o_scl(scl),
    .o_sda(host_sda)
  );

  // ****************
  // reference model and checks
  // ****************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // power-up state: trip 80 C, release 75 C in half degrees
  task automatic mreset();
    trip = 160;
    rel = 150;
    cfg = 5'h00;
    cnt = 0;
    alarm = 1'b0;
    dir_up = 1'b1;
  endtask

  function automatic logic [15:0] regv(input logic [1:0] p);
    case (p)
      `OTA_PTR_TEMP: return {last_t, 5'h00};
      `OTA_PTR_CFG: return {3'h0, cfg, 3'h0, cfg};
      `OTA_PTR_REL: return {rel[8:0], 7'h00};
      default: return {trip[8:0], 7'h00};
    endcase
  endfunction

  // temperature whose upper nine bits equal v, low bits set
  function automatic logic [10:0] tv(input int v);
    return {v[8:0], 2'h3};
  endfunction

  task automatic chkpin();
    chk({15'h0, alarm_oe | alarm_out}, {15'h0, (cfg[2] ? alarm : !alarm)});
  endtask

  task automatic rreg(input logic [1:0] p);
    logic [15:0] d;
    logic nak;
    u_host.rd(dev, p, d, nak);
    if (cfg[1])
      alarm = 1'b0;
    chk({15'h0, nak}, 16'h0000);
    chk(d, regv(p));
    chkpin();
  endtask

  task automatic wreg(input logic [1:0] p, input logic [15:0] d);
    logic nak;
    int n = (p == `OTA_PTR_CFG) ? 1 : 2;
    u_host.wr(dev, p, n, d, nak);
    chk({15'h0, nak}, 16'h0000);
    if (p == `OTA_PTR_CFG && d[8] && !cfg[0] && d[9])
      alarm = 1'b0;
    if (p == `OTA_PTR_CFG)
      cfg = d[12:8];
    if (p == `OTA_PTR_TRIP)
      trip = $signed({d[15:8], d[7]});
    if (p == `OTA_PTR_REL)
      rel = $signed({d[15:8], d[7]});
    chkpin();
  endtask

  // one conversion strobe, then model step and pin compare
  task automatic cv(input logic [10:0] t);
    int v;
    @(posedge i_sys_clk) conv <= {1'b1, t};
    @(posedge i_sys_clk) conv.valid <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1;
    if (!cfg[0])
    begin
      last_t = t;
      v = $signed(t[10:2]);
      cnt = (dir_up ? v > trip : v < rel) ? cnt + 1 : 0;
      if (cnt >= nq[cfg[4:3]])
      begin
        cnt = 0;
        dir_up = !dir_up;
        alarm = cfg[1] | !dir_up;
      end
    end
    chk({15'h0, conv_run}, {15'h0, !cfg[0]});
    chkpin();
  endtask

  // ****************
  // scenarios
  // ****************
  initial
  begin
    void'($urandom(60));
    dev = {`OTA_ADDR_HI, pins};
    mreset();
    repeat (2) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1;
    chk({13'h0, sda_oe, conv_run, alarm_oe}, 16'h0007);
    for (int p = 1; p < 4; p++) rreg(p[1:0]);
    // random limits, trip kept above release, junk in low bits
    for (int i = 0; i < 3; i++)
    begin
      r = $urandom_range(200) - 100;
      wreg(`OTA_PTR_REL, {r[8:0], 7'h7f});
      r = r + 1 + $urandom_range(50);
      wreg(`OTA_PTR_TRIP, {r[8:0], 7'h55});
      rreg(`OTA_PTR_REL);
      rreg(`OTA_PTR_TRIP);
    end
    // every fault count, broken run, equal upper bits, both polarities
    for (int q = 0; q < 4; q++)
    begin
      wreg(`OTA_PTR_CFG, {3'h0, q[1:0], q[0], 2'h0, 8'h00});
      repeat (nq[q] - 1) cv(tv(trip + 1));
      cv(tv(trip));
      repeat (nq[q]) cv(tv(trip + 1));
      rreg(`OTA_PTR_TEMP);
      repeat (nq[q]) cv(tv(rel - 1));
    end
    // comparator alarm through shutdown, registers still reachable
    wreg(`OTA_PTR_CFG, 16'h0000);
    cv(tv(trip + 1));
    wreg(`OTA_PTR_CFG, 16'h0100);
    cv(tv(rel - 1));
    wreg(`OTA_PTR_TRIP, 16'h6400);
    rreg(`OTA_PTR_TRIP);
    rreg(`OTA_PTR_TEMP);
    wreg(`OTA_PTR_CFG, 16'h0000);
    cv(tv(rel - 1));
    // interrupt: read clears, opposite limit next, shutdown clears
    wreg(`OTA_PTR_CFG, 16'h0600);
    cv(tv(trip + 1));
    cv(tv(trip + 1));
    rreg(`OTA_PTR_CFG);
    cv(tv(trip + 1));
    cv(tv(rel - 1));
    wreg(`OTA_PTR_CFG, 16'h0700);
    wreg(`OTA_PTR_CFG, 16'h0600);
    // foreign address is refused and changes nothing
    u_host.wr(dev ^ 7'h01, `OTA_PTR_TRIP, 2, 16'h0000, nak_x);
    chk({15'h0, nak_x}, 16'h0001);
    rreg(`OTA_PTR_TRIP);
    // random comparator traffic around both limits
    wreg(`OTA_PTR_CFG, {3'h0, 5'($urandom) & 5'h1c, 8'h00});
    repeat (40) cv(11'((rel - 2) * 4 + $urandom_range((trip - rel + 5) * 4)));
    // frozen clock enable ignores a firing conversion, a new strobe of the same temperature fires once enabled
    wreg(`OTA_PTR_CFG, 16'h0000);
    @(posedge i_sys_clk) clk_en <= 1'b0;
    conv <= {1'b1, (dir_up ? tv(trip + 1) : tv(rel - 1))};
    @(posedge i_sys_clk) conv.valid <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    clk_en <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #1;
    chkpin();
    cv(dir_up ? tv(trip + 1) : tv(rel - 1));
    // reset in mid-run restores the defaults
    @(posedge i_sys_clk) i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    mreset();
    repeat (3) @(posedge i_sys_clk);
    #1;
    chkpin();
    for (int p = 1; p < 4; p++) rreg(p[1:0]);
    give_verdict();
  end

  // watchdog against a hung bus transfer
  initial
  begin
    #300000;
    miscompares++;
    give_verdict();
  end
endmodule // ota_alarm_tb
